// ===== verilog/sptm_timer.sv
// split timer block: first/second timer split mode and the third auto-reload timer
//
// Contract
// RULE1: mode 3 splits first timer into bytes
// RULE2: low byte uses first timer's own controls
// RULE3: low byte counts clock or external edges
// RULE4: high byte is a timer only
// RULE5: high byte runs on second timer's run
// RULE6: high byte overflow sets second timer flag
// RULE7: second timer: no external clock, no flag
// RULE8: second timer overflow still drives baud/converter
// RULE9: second timer stops only in mode 3
// RULE10: third timer high overflow sets high flag
// RULE11: high flag requests interrupt, software clears
// RULE12: low byte overflow always sets low flag
// RULE13: low flag interrupts when both enables set
// RULE14: split bit picks two 8-bit or 16-bit
// RULE15: run bit gates high byte in split
// RULE16: clock is system_clock/12 or external/8
// RULE17: per-byte selects pick system or external source
// RULE18: unused control bits read zero, ignore writes
// RULE19: reload on the same tick as flag
// RULE20: control register resets to zero
`timescale 1ns/10ps
`include "sptm_defs.svh"

module sptm_timer
#(
	parameter int SYS_DIV = `SPTM_SYS_DIV,
	parameter int EXT_DIV = `SPTM_EXT_DIV
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clockEnable,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrRead,
	output logic [7:0] sfrRdData,
	input wire sptm_pkg::sptm_ab_cfg_t tmrACfg,
	input wire sptm_pkg::sptm_ab_cfg_t tmrBCfg,
	input wire logic abTick,
	input wire logic tmrAPin,
	input wire logic tmrBPin,
	input wire logic tmrAGatePin,
	input wire logic tmrBGatePin,
	input wire logic tmrAFlagClear,
	input wire logic tmrBFlagClear,
	output logic tmrAOverflowFlag,
	output logic tmrBOverflowFlag,
	output logic tmrBOverflowPulse,
	output logic [15:0] tmrACount,
	output logic [15:0] tmrBCount,
	input wire logic tmrCExtClock,
	input wire logic tmrCHighClockSelect,
	input wire logic tmrCLowClockSelect,
	input wire logic [15:0] tmrCReload,
	input wire logic tmrCIrqEnable,
	output logic tmrCIrq,
	output logic [15:0] tmrCCount
);

	initial
	begin
		if (SYS_DIV < 2 || SYS_DIV > 256 || EXT_DIV < 2 || EXT_DIV > 256)
		begin
			$error("sptm_timer: divider out of range");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state

	sptm_pkg::sptm_ctrl_t ctrl_reg, ctrl_next;
	logic [15:0] cntA_reg, cntA_next;
	logic [15:0] cntB_reg, cntB_next;
	logic [15:0] cntC_reg, cntC_next;
	logic tfA_reg, tfA_next;
	logic tfB_reg, tfB_next;
	logic bPulse_reg, bPulse_next;
	logic [7:0] sysDiv_reg, sysDiv_next;
	logic [7:0] extDiv_reg, extDiv_next;
	logic pinAPrev_reg, pinBPrev_reg, extPrev_reg;
	logic [7:0] rdData_reg, rdData_next;

	////////////////////////////////////////////////////////////////////////////////
	// step of a mode 0/1/2 timer: returns {overflow, new count}

	function automatic logic [16:0] sptm_step(input logic [15:0] cnt, input sptm_pkg::sptm_mode_t m);
		logic [13:0] c13;
		logic [16:0] r;
		c13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
		r = {1'b0, cnt};
		case (m)
			sptm_pkg::SPTM_MODE_13BIT:
				r = {c13[13], c13[12:5], cnt[7:5], c13[4:0]};
			sptm_pkg::SPTM_MODE_16BIT:
				r = {1'b0, cnt} + 17'h00001;
			sptm_pkg::SPTM_MODE_8RELOAD:
				r = (cnt[7:0] == 8'hFF) ? {1'b1, cnt[15:8], cnt[15:8]} : {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
			default:
				r = {1'b0, cnt};
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// tick sources and run conditions

	logic aSplit;
	logic aEdge, bEdge, extEdge;
	logic aRun, bRun;
	logic aLowTick, aHighTick, bTick;
	logic sysDivTick, extDivTick, cLowTick, cHighTick;
	logic cSplit, cHighOv, cLowOv;
	logic aLowOv, aHighOv, aFullOv, bOv;
	logic ctrlWrite;
	logic [16:0] aStep, bStep;

	assign aSplit = (tmrACfg.mode == sptm_pkg::SPTM_MODE_SPLIT); // RULE1
	assign aEdge = pinAPrev_reg & ~tmrAPin;
	assign bEdge = pinBPrev_reg & ~tmrBPin;
	assign extEdge = ~extPrev_reg & tmrCExtClock;
	assign aRun = tmrACfg.run & (~tmrACfg.gate | tmrAGatePin); // RULE2
	// in split mode the second timer is run by its mode alone
	assign bRun = aSplit ? (tmrBCfg.mode != sptm_pkg::SPTM_MODE_SPLIT) // RULE9
		: (tmrBCfg.run & (~tmrBCfg.gate | tmrBGatePin));
	assign aLowTick = clockEnable & aRun & (tmrACfg.counterSelect ? aEdge : abTick); // RULE3
	assign aHighTick = clockEnable & aSplit & tmrBCfg.run & abTick; // RULE4 RULE5
	assign bTick = clockEnable & bRun
		& ((tmrBCfg.counterSelect & ~aSplit) ? bEdge : abTick); // RULE7
	assign aStep = sptm_step(cntA_reg, tmrACfg.mode);
	assign bStep = sptm_step(cntB_reg, tmrBCfg.mode);
	assign aLowOv = aSplit & aLowTick & (cntA_reg[7:0] == 8'hFF);
	assign aHighOv = aHighTick & (cntA_reg[15:8] == 8'hFF);
	assign aFullOv = ~aSplit & aLowTick & aStep[16];
	assign bOv = bTick & bStep[16];

	assign sysDivTick = clockEnable & (sysDiv_reg == 8'(SYS_DIV - 1));
	assign extDivTick = clockEnable & extEdge & (extDiv_reg == 8'(EXT_DIV - 1));
	// per-byte select picks system clock, else the shared source
	assign cLowTick = tmrCLowClockSelect ? clockEnable // RULE17
		: (ctrl_reg.extClockSelect ? extDivTick : sysDivTick); // RULE16
	assign cHighTick = tmrCHighClockSelect ? clockEnable
		: (ctrl_reg.extClockSelect ? extDivTick : sysDivTick);
	assign cSplit = ctrl_reg.splitEnable; // RULE14
	assign cLowOv = cSplit ? (cLowTick & (cntC_reg[7:0] == 8'hFF)) // RULE15
		: (ctrl_reg.run & cLowTick & (cntC_reg[7:0] == 8'hFF));
	assign cHighOv = cSplit ? (ctrl_reg.run & cHighTick & (cntC_reg[15:8] == 8'hFF))
		: (ctrl_reg.run & cLowTick & (cntC_reg == 16'hFFFF)); // RULE10
	assign ctrlWrite = clockEnable & sfrWrite & (sfrAddr == `SPTM_TMR_C_CTRL_ADDR);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		ctrl_next = ctrl_reg;
		cntA_next = cntA_reg;
		cntB_next = cntB_reg;
		cntC_next = cntC_reg;
		tfA_next = tfA_reg;
		tfB_next = tfB_reg;
		bPulse_next = 1'b0;
		sysDiv_next = sysDiv_reg;
		extDiv_next = extDiv_reg;
		rdData_next = rdData_reg;
		if (clockEnable)
		begin
			// dividers
			sysDiv_next = sysDivTick ? 8'h00 : sysDiv_reg + 8'h01;
			if (extEdge)
			begin
				extDiv_next = extDivTick ? 8'h00 : extDiv_reg + 8'h01;
			end
			// first timer
			if (aSplit)
			begin
				if (aLowTick)
				begin
					cntA_next[7:0] = cntA_reg[7:0] + 8'h01; // RULE1
				end
				if (aHighTick)
				begin
					cntA_next[15:8] = cntA_reg[15:8] + 8'h01; // RULE4
				end
			end
			else if (aLowTick)
			begin
				cntA_next = aStep[15:0];
			end
			// second timer
			if (bTick)
			begin
				cntB_next = bStep[15:0];
			end
			bPulse_next = bOv; // RULE8
			// flags: a hardware set wins over a clear in the same cycle
			if (tmrAFlagClear)
			begin
				tfA_next = 1'b0;
			end
			if (aLowOv | aFullOv)
			begin
				tfA_next = 1'b1; // RULE2
			end
			if (tmrBFlagClear)
			begin
				tfB_next = 1'b0;
			end
			if (aSplit ? aHighOv : bOv) // RULE6 RULE7
			begin
				tfB_next = 1'b1;
			end
			// third timer control register
			if (ctrlWrite)
			begin
				ctrl_next = sfrWrData & `SPTM_TMR_C_CTRL_MASK; // RULE18
			end
			if (cHighOv)
			begin
				ctrl_next.highOverflow = 1'b1; // RULE11
			end
			if (cLowOv)
			begin
				ctrl_next.lowOverflow = 1'b1; // RULE12
			end
			// third timer counting with reload on overflow
			if (cSplit)
			begin
				if (cLowTick)
				begin
					cntC_next[7:0] = cLowOv ? tmrCReload[7:0] : cntC_reg[7:0] + 8'h01; // RULE19
				end
				if (ctrl_reg.run & cHighTick)
				begin
					cntC_next[15:8] = cHighOv ? tmrCReload[15:8] : cntC_reg[15:8] + 8'h01;
				end
			end
			else if (ctrl_reg.run & cLowTick)
			begin
				cntC_next = cHighOv ? tmrCReload : cntC_reg + 16'h0001; // RULE19
			end
			// register read
			if (sfrRead)
			begin
				rdData_next = (sfrAddr == `SPTM_TMR_C_CTRL_ADDR)
					? (ctrl_reg & `SPTM_TMR_C_CTRL_MASK) : 8'h00; // RULE18
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `SPTM_TMR_C_CTRL_RESET; // RULE20
			cntA_reg <= 16'h0000;
			cntB_reg <= 16'h0000;
			cntC_reg <= 16'h0000;
			tfA_reg <= 1'b0;
			tfB_reg <= 1'b0;
			bPulse_reg <= 1'b0;
			sysDiv_reg <= 8'h00;
			extDiv_reg <= 8'h00;
			pinAPrev_reg <= 1'b0;
			pinBPrev_reg <= 1'b0;
			extPrev_reg <= 1'b0;
			rdData_reg <= 8'h00;
		end
		else if (clockEnable)
		begin
			ctrl_reg <= ctrl_next;
			cntA_reg <= cntA_next;
			cntB_reg <= cntB_next;
			cntC_reg <= cntC_next;
			tfA_reg <= tfA_next;
			tfB_reg <= tfB_next;
			bPulse_reg <= bPulse_next;
			sysDiv_reg <= sysDiv_next;
			extDiv_reg <= extDiv_next;
			pinAPrev_reg <= tmrAPin;
			pinBPrev_reg <= tmrBPin;
			extPrev_reg <= tmrCExtClock;
			rdData_reg <= rdData_next;
		end
	end

	assign sfrRdData = rdData_reg;
	assign tmrAOverflowFlag = tfA_reg;
	assign tmrBOverflowFlag = tfB_reg;
	assign tmrBOverflowPulse = bPulse_reg;
	assign tmrACount = cntA_reg;
	assign tmrBCount = cntB_reg;
	assign tmrCCount = cntC_reg;
	assign tmrCIrq = tmrCIrqEnable & (ctrl_reg.highOverflow // RULE11
		| (ctrl_reg.lowOverflow & ctrl_reg.lowIrqEnable)); // RULE13

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_c_wrap;
		cHighOv && !cSplit;
	endsequence

	sequence s_c_reloaded;
		cntC_reg == $past(tmrCReload) && ctrl_reg.highOverflow;
	endsequence

	a_c_high_reload: assert property (s_c_wrap |=> s_c_reloaded) // RULE10 RULE19
		else $error("third timer did not reload and flag on 16-bit wrap");

	a_c_low_flag: assert property (cLowOv |=> ctrl_reg.lowOverflow) // RULE12
		else $error("low byte wrap did not set low flag");

	a_c_flag_sticky: assert property (
		ctrl_reg.highOverflow && !ctrlWrite |=> ctrl_reg.highOverflow) // RULE11
		else $error("high flag cleared without a write");

	a_c_irq_low: assert property (
		tmrCIrqEnable && ctrl_reg.lowOverflow && ctrl_reg.lowIrqEnable |-> tmrCIrq) // RULE13
		else $error("low overflow interrupt missing");

	a_c_irq_quiet: assert property (
		!ctrl_reg.highOverflow && !ctrl_reg.lowOverflow |-> !tmrCIrq) // RULE11
		else $error("interrupt without a flag");

	a_unused_zero: assert property (
		sfrRead && clockEnable |=> sfrRdData[4] == 1'b0 && sfrRdData[1] == 1'b0) // RULE18
		else $error("unused control bits read non-zero");

	a_c_high_hold: assert property (
		cSplit && !ctrl_reg.run && clockEnable |=> cntC_reg[15:8] == $past(cntC_reg[15:8])) // RULE15
		else $error("split high byte moved while stopped");

	a_a_high_run: assert property (
		aSplit && !tmrBCfg.run |=> cntA_reg[15:8] == $past(cntA_reg[15:8])) // RULE5
		else $error("split high byte moved without second run bit");

	a_b_flag_split: assert property (
		aSplit && !aHighOv && !tfB_reg |=> !tfB_reg) // RULE7
		else $error("second timer flag set by its own overflow in split");

	a_b_mode3_stop: assert property (
		aSplit && tmrBCfg.mode == sptm_pkg::SPTM_MODE_SPLIT |=> cntB_reg == $past(cntB_reg)) // RULE9
		else $error("second timer counted in mode 3");

	a_a_high_flag: assert property (aHighOv && clockEnable |=> tfB_reg) // RULE6
		else $error("split high byte overflow did not set second flag");

	a_b_baud_pulse: assert property (bOv |=> tmrBOverflowPulse) // RULE8
		else $error("second timer overflow pulse missing");

endmodule

// ===== verilog/sptm_defs.svh
// register address, field positions, reset values and timing counts for the split timer block
`ifndef SPTM_DEFS_SVH
`define SPTM_DEFS_SVH

`define SPTM_TMR_C_CTRL_ADDR 8'hC8
`define SPTM_TMR_C_CTRL_RESET 8'h00
// bits 4 and 1 are unused and always read back as zero
`define SPTM_TMR_C_CTRL_MASK 8'hED

`define SPTM_BIT_HIGH_OVF 7
`define SPTM_BIT_LOW_OVF 6
`define SPTM_BIT_LOW_IRQ_EN 5
`define SPTM_BIT_SPLIT 3
`define SPTM_BIT_RUN 2
`define SPTM_BIT_EXT_CLK 0

// divided system clock and divided external clock ratios
`define SPTM_SYS_DIV 12
`define SPTM_EXT_DIV 8

`endif

// ===== verilog/sptm_pkg.sv
// types shared by the split timer block
package sptm_pkg;

	// operating modes of the first and second timers
	typedef enum logic [1:0]
	{
		SPTM_MODE_13BIT = 2'h0,
		SPTM_MODE_16BIT = 2'h1,
		SPTM_MODE_8RELOAD = 2'h2,
		SPTM_MODE_SPLIT = 2'h3
	} sptm_mode_t;

	// third timer control register fields, msb first
	typedef struct packed
	{
		logic highOverflow;
		logic lowOverflow;
		logic lowIrqEnable;
		logic unused4;
		logic splitEnable;
		logic run;
		logic unused1;
		logic extClockSelect;
	} sptm_ctrl_t;

	// per-timer controls of the first and second timers
	typedef struct packed
	{
		sptm_mode_t mode;
		logic run;
		logic counterSelect;
		logic gate;
	} sptm_ab_cfg_t;

endpackage

// ===== test/sptm_timer_bench.sv
// self-checking bench for the split timer block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("Error %0t: got %h expected %h", $time, g, e); end end

module sptm_timer_bench;
	logic clock, rst_n, clockEnable, sfrWrite, sfrRead, abTick, abOn, extOn;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData, rd;
	sptm_pkg::sptm_ab_cfg_t tmrACfg, tmrBCfg;
	logic tmrAPin, tmrBPin, tmrAFlagClear, tmrBFlagClear, gateA;
	logic tmrAOverflowFlag, tmrBOverflowFlag, tmrBOverflowPulse;
	logic [15:0] tmrACount, tmrBCount, tmrCCount, tmrCReload, snap;
	logic tmrCExtClock, tmrCHighClockSelect, tmrCLowClockSelect, tmrCIrqEnable, tmrCIrq;
	integer seed = 32'h3BD99F4F;
	int mismatches, samples_checked, n;

	sptm_timer i_sptm_timer (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
		.sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrRead(sfrRead),
		.sfrRdData(sfrRdData), .tmrACfg(tmrACfg), .tmrBCfg(tmrBCfg), .abTick(abTick),
		.tmrAPin(tmrAPin), .tmrBPin(tmrBPin), .tmrAGatePin(gateA), .tmrBGatePin(1'h0),
		.tmrAFlagClear(tmrAFlagClear), .tmrBFlagClear(tmrBFlagClear),
		.tmrAOverflowFlag(tmrAOverflowFlag), .tmrBOverflowFlag(tmrBOverflowFlag),
		.tmrBOverflowPulse(tmrBOverflowPulse), .tmrACount(tmrACount), .tmrBCount(tmrBCount),
		.tmrCExtClock(tmrCExtClock), .tmrCHighClockSelect(tmrCHighClockSelect),
		.tmrCLowClockSelect(tmrCLowClockSelect), .tmrCReload(tmrCReload),
		.tmrCIrqEnable(tmrCIrqEnable), .tmrCIrq(tmrCIrq), .tmrCCount(tmrCCount));

	initial
	begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	// random timebase, unused pin noise and the external clock, toggled every clock for half the system clock rate
	always @(posedge clock)
	begin
		abTick <= abOn & 1'($random(seed));
		tmrBPin <= 1'($random(seed));
		if (extOn)
			tmrCExtClock <= ~tmrCExtClock;
	end

	////////////////////////////////////////////////////////////////////////////////
	// expectations and helpers
	function automatic logic [7:0] expCtrl(input logic [7:0] w);
		return w & 8'hED;
	endfunction

	function automatic sptm_pkg::sptm_ab_cfg_t cfg(input sptm_pkg::sptm_mode_t m,
		input logic r, input logic c);
		return '{mode: m, run: r, counterSelect: c, gate: 1'h0};
	endfunction

	function automatic logic pick(input int w);
		return w == 0 ? tmrCIrq : (w == 1 ? tmrAOverflowFlag : tmrBOverflowFlag);
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		sfrAddr <= a;
		sfrWrData <= d;
		sfrWrite <= 1'h1;
		@(posedge clock);
		sfrWrite <= 1'h0;
		// later samples must see the state this write produced
		@(negedge clock);
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		sfrAddr <= a;
		sfrRead <= 1'h1;
		@(posedge clock);
		sfrRead <= 1'h0;
		@(negedge clock);
		rd = sfrRdData;
	endtask

	// cycles between two changes of the third timer's count
	task automatic waitC(input int lim);
		n = 0;
		snap = tmrCCount;
		while (tmrCCount === snap && n < lim)
		begin
			@(negedge clock);
			n++;
		end
	endtask

	task automatic waitFor(input int w, input int lim);
		n = 0;
		while (pick(w) !== 1'h1 && n < lim)
		begin
			@(negedge clock);
			n++;
		end
		`CHK(pick(w), 1'h1)
	endtask

	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#(95000 * 25);
		mismatches++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rst_n = 1'h0;
		clockEnable = 1'h1;
		{sfrWrite, sfrRead, abOn, extOn, tmrAPin, tmrCExtClock, gateA} = 7'h00;
		{tmrAFlagClear, tmrBFlagClear, tmrCHighClockSelect, tmrCLowClockSelect} = 4'h0;
		sfrAddr = 8'h00;
		sfrWrData = 8'h00;
		tmrACfg = cfg(sptm_pkg::SPTM_MODE_13BIT, 1'h0, 1'h0);
		tmrBCfg = cfg(sptm_pkg::SPTM_MODE_13BIT, 1'h0, 1'h0);
		tmrCReload = 16'h0000;
		tmrCIrqEnable = 1'h1;
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		rdr(8'hC8);
		`CHK(rd, 8'h00)
		wr(8'hC8, 8'hFF);
		rdr(8'hC8);
		`CHK(rd, expCtrl(8'hFF))
		wr(8'hC8, 8'h00);
		wr(8'h55, 8'($random(seed)));
		rdr(8'h55);
		`CHK(rd, 8'h00)
		clockEnable <= 1'h0;
		wr(8'hC8, 8'h04);
		clockEnable <= 1'h1;
		rdr(8'hC8);
		`CHK(rd, 8'h00)
		$display("test registers done");
		wr(8'hC8, 8'h04);
		waitC(100);
		waitC(100);
		`CHK(n, 12)
		extOn <= 1'h1;
		wr(8'hC8, 8'h05);
		waitC(200);
		waitC(200);
		`CHK(n, 16)
		tmrCLowClockSelect <= 1'h1;
		wr(8'hC8, 8'h0D);
		waitC(200);
		waitC(200);
		`CHK(n, 1)
		extOn <= 1'h0;
		$display("test clock sources done");
		tmrCReload <= 16'($random(seed));
		wr(8'hC8, 8'h28);
		snap = tmrCCount;
		waitFor(0, 300);
		`CHK(tmrCCount[7:0], tmrCReload[7:0])
		`CHK(tmrCCount[15:8], snap[15:8])
		rdr(8'hC8);
		`CHK(rd, 8'h68)
		wr(8'hC8, 8'h08);
		@(negedge clock);
		`CHK(tmrCIrq, 1'h0)
		tmrCHighClockSelect <= 1'h1;
		wr(8'hC8, 8'h0C);
		waitFor(0, 300);
		`CHK(tmrCCount[15:8], tmrCReload[15:8])
		repeat (20) @(negedge clock);
		`CHK(tmrCIrq, 1'h1)
		$display("test split third timer done");
		tmrCReload <= {8'hFF, 8'($random(seed))};
		// stop first so no overflow can re-set the flags on the clearing write
		wr(8'hC8, 8'h00);
		wr(8'hC8, 8'h04);
		waitFor(0, 70000);
		`CHK(tmrCCount, tmrCReload)
		wr(8'hC8, 8'h04);
		waitFor(0, 300);
		`CHK(tmrCCount, tmrCReload)
		rdr(8'hC8);
		`CHK(rd, 8'hC4)
		$display("test wide third timer done");
		abOn <= 1'h1;
		tmrACfg <= cfg(sptm_pkg::SPTM_MODE_SPLIT, 1'h1, 1'h1);
		@(negedge clock);
		snap = tmrACount;
		repeat (5)
		begin
			@(posedge clock) tmrAPin <= 1'h1;
			@(posedge clock) tmrAPin <= 1'h0;
		end
		repeat (3) @(negedge clock);
		`CHK(tmrACount[7:0], snap[7:0] + 8'h05)
		`CHK(tmrACount[15:8], snap[15:8])
		tmrACfg <= cfg(sptm_pkg::SPTM_MODE_SPLIT, 1'h1, 1'h0);
		repeat (60) @(negedge clock);
		`CHK(tmrACount[7:0] !== snap[7:0] + 8'h05, 1'h1)
		tmrACfg <= cfg(sptm_pkg::SPTM_MODE_SPLIT, 1'h0, 1'h0);
		@(negedge clock);
		snap = tmrACount;
		repeat (30) @(negedge clock);
		`CHK(tmrACount[7:0], snap[7:0])
		tmrACfg <= '{mode: sptm_pkg::SPTM_MODE_SPLIT, run: 1'h1,
			counterSelect: 1'h0, gate: 1'h1};
		repeat (30) @(negedge clock);
		`CHK(tmrACount[7:0], snap[7:0])
		gateA <= 1'h1;
		repeat (30) @(negedge clock);
		`CHK(tmrACount[7:0] !== snap[7:0], 1'h1)
		tmrBCfg <= cfg(sptm_pkg::SPTM_MODE_13BIT, 1'h1, 1'h0);
		waitFor(2, 3000);
		tmrACfg <= cfg(sptm_pkg::SPTM_MODE_SPLIT, 1'h1, 1'h0);
		waitFor(1, 3000);
		tmrBCfg <= cfg(sptm_pkg::SPTM_MODE_8RELOAD, 1'h0, 1'h1);
		@(posedge clock) tmrBFlagClear <= 1'h1;
		@(posedge clock) tmrBFlagClear <= 1'h0;
		n = 0;
		repeat (2000)
		begin
			@(negedge clock);
			n += tmrBOverflowPulse;
		end
		`CHK(n > 0, 1'h1)
		`CHK(tmrBOverflowFlag, 1'h0)
		tmrBCfg <= cfg(sptm_pkg::SPTM_MODE_SPLIT, 1'h1, 1'h0);
		@(negedge clock);
		snap = tmrBCount;
		repeat (50) @(negedge clock);
		`CHK(tmrBCount, snap)
		$display("test split first timer done");
		test_done;
	end
endmodule
